/* File: dps_port_engine.sv */
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
module dps_port_engine
   import dps_pkg::*;
#(
   parameter logic [CNT_W-1:0] ACC_CYC = CNT_W'(ACCESS_CYC),
   parameter logic [CNT_W-1:0] SET_CYC = CNT_W'(SETUP_CYC)
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   dps_eng_if.eng                  eng,
   output logic [ADDR_W-1:0]       port_address,
   output logic [DATA_W-1:0]       port_data_out,
   output logic                    port_data_oe_n,
   input  wire logic [DATA_W-1:0]  port_data_in,
   output logic                    select_active_low_n,
   output logic                    select_active_high,
   output logic                    port_write_n,
   output logic                    port_output_enable_n,
   output logic                    flag_space_select_n,
   input  wire logic               port_conflict_n,
   input  wire logic               port_alert_n
);
   dps_state_t          state, next_state;
   dps_op_t             op, next_op;
   logic [CNT_W-1:0]    cnt, next_cnt;
   logic [DATA_W-1:0]   rdata, next_rdata;
   logic                done, next_done, cf_seen, next_cf_seen;
   logic [ADDR_W-1:0]   next_address;
   logic [DATA_W-1:0]   next_data_out;
   logic                next_data_oe_n, next_sel_n, next_sel, next_wr_n, next_oe_n, next_flag_n;
   logic [DATA_W-1:0]   din_s1, din_s2;
   logic [1:0]          cf_s, al_s;
   logic                conflict, flag_op, wr_op;

   // Device pins are asynchronous to hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         din_s1 <= '0;
         din_s2 <= '0;
         cf_s   <= 2'h3;
         al_s   <= 2'h3;
      end else begin
         din_s1 <= port_data_in;
         din_s2 <= din_s1;
         cf_s   <= {cf_s[0], port_conflict_n};
         al_s   <= {al_s[0], port_alert_n};
      end
   end

   assign conflict = !cf_s[1];
   assign flag_op  = (op == DPS_OP_FLAG_RD) || (op == DPS_OP_FLAG_WR);
   assign wr_op    = (op == DPS_OP_MEM_WR) || (op == DPS_OP_FLAG_WR);

   always_comb begin
      next_state     = state;
      next_op        = op;
      next_cnt       = cnt;
      next_rdata     = rdata;
      next_done      = 1'b0;
      next_cf_seen   = 1'b0;
      next_address   = port_address;
      next_data_out  = port_data_out;
      next_data_oe_n = port_data_oe_n;
      next_sel_n     = select_active_low_n;
      next_sel       = select_active_high;
      next_wr_n      = port_write_n;
      next_oe_n      = port_output_enable_n;
      next_flag_n    = flag_space_select_n;
      unique case (state)
         DPS_IDLE: begin
            if (eng.start) begin
               next_op    = eng.op;
               next_cnt   = SET_CYC;
               next_state = DPS_SETUP;
               if ((eng.op == DPS_OP_FLAG_RD) || (eng.op == DPS_OP_FLAG_WR)) begin
                  // Memory stays deselected whenever the flag space is open
                  next_address = {{(ADDR_W-FLAG_ADDR_W){1'b0}},
                                  eng.addr[FLAG_ADDR_W-1:0]};
                  next_sel_n   = 1'b1;
                  next_sel     = 1'b0;
                  next_flag_n  = 1'b0;
               end else begin
                  next_address = eng.addr;
                  next_sel_n   = 1'b0;
                  next_sel     = 1'b1;
                  next_flag_n  = 1'b1;
               end
               if ((eng.op == DPS_OP_MEM_WR) || (eng.op == DPS_OP_FLAG_WR)) begin
                  next_data_out  = eng.wdata;
                  next_data_oe_n = 1'b0;
               end
            end
         end
         DPS_SETUP: begin
            if (cnt > CNT_W'(1)) begin
               next_cnt = cnt - CNT_W'(1);
            end else begin
               next_cnt   = ACC_CYC;
               next_state = DPS_STROBE;
               if (wr_op) begin
                  next_wr_n = 1'b0;
               end else begin
                  next_oe_n = 1'b0;
               end
            end
         end
         DPS_STROBE: begin
            // A memory read or write that loses arbitration is held until the conflict clears; flag accesses are not held
            if (conflict && !flag_op) begin
               next_cf_seen = 1'b1;
            end else if (cnt > CNT_W'(1)) begin
               next_cnt = cnt - CNT_W'(1);
            end else begin
               next_cnt   = SET_CYC;
               next_state = DPS_HOLD;
               next_wr_n  = 1'b1;
               next_oe_n  = 1'b1;
               if (!wr_op) begin
                  // All eight lines carry the flag; bit 0 is taken as the value
                  next_rdata = flag_op ? {DATA_W{din_s2[0]}} : din_s2;
               end
            end
         end
         DPS_HOLD: begin
            if (cnt > CNT_W'(1)) begin
               next_cnt = cnt - CNT_W'(1);
            end else begin
               next_state     = DPS_IDLE;
               next_done      = 1'b1;
               next_data_oe_n = 1'b1;
               next_sel_n     = 1'b1;
               next_sel       = 1'b0;
               next_flag_n    = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state                <= DPS_IDLE;
         op                   <= DPS_OP_MEM_RD;
         cnt                  <= '0;
         rdata                <= '0;
         done                 <= 1'b0;
         cf_seen              <= 1'b0;
         port_address         <= '0;
         port_data_out        <= '0;
         port_data_oe_n       <= 1'b1;
         select_active_low_n  <= 1'b1;
         select_active_high   <= 1'b0;
         port_write_n         <= 1'b1;
         port_output_enable_n <= 1'b1;
         flag_space_select_n  <= 1'b1;
      end else begin
         state                <= next_state;
         op                   <= next_op;
         cnt                  <= next_cnt;
         rdata                <= next_rdata;
         done                 <= next_done;
         cf_seen              <= next_cf_seen;
         port_address         <= next_address;
         port_data_out        <= next_data_out;
         port_data_oe_n       <= next_data_oe_n;
         select_active_low_n  <= next_sel_n;
         select_active_high   <= next_sel;
         port_write_n         <= next_wr_n;
         port_output_enable_n <= next_oe_n;
         flag_space_select_n  <= next_flag_n;
      end
   end

   assign eng.busy          = (state != DPS_IDLE);
   assign eng.done          = done;
   assign eng.rdata         = rdata;
   assign eng.conflict_seen = cf_seen;
   assign eng.conflict_lvl  = conflict;
   assign eng.alert_lvl     = !al_s[1];
endmodule

/* File: dps_pkg.sv */
package dps_pkg;
   // Bus clock and pin timing
   localparam int CLK_MHZ      = 250;
   localparam int ACCESS_NS    = 55;
   localparam int SETUP_NS     = 10;
   localparam int ACCESS_CYC   = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W        = 8;

   // Device geometry
   localparam int ADDR_W       = 16;
   localparam int DATA_W       = 8;
   localparam int FLAG_ADDR_W  = 3;

   // Register byte offsets
   localparam logic [7:0] OFS_ADDR   = 8'h00;
   localparam logic [7:0] OFS_WDATA  = 8'h04;
   localparam logic [7:0] OFS_CMD    = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0C;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   localparam logic [7:0] OFS_IRQ    = 8'h14;
   localparam logic [7:0] OFS_MASK   = 8'h18;

   // Command register fields
   localparam int CMD_START    = 0;
   localparam int CMD_OP_LO    = 1;
   localparam int CMD_OP_HI    = 2;

   // Status and interrupt bit positions
   localparam int ST_BUSY      = 0;
   localparam int ST_CONFLICT  = 1;
   localparam int ST_ALERT     = 2;
   localparam int IRQ_DONE     = 0;
   localparam int IRQ_CONFLICT = 1;
   localparam int IRQ_ALERT    = 2;
   localparam int IRQ_W        = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   typedef enum logic [1:0] {
      DPS_OP_MEM_RD  = 2'h0,
      DPS_OP_MEM_WR  = 2'h1,
      DPS_OP_FLAG_RD = 2'h2,
      DPS_OP_FLAG_WR = 2'h3
   } dps_op_t;

   typedef enum logic [1:0] {
      DPS_IDLE   = 2'h0,
      DPS_SETUP  = 2'h1,
      DPS_STROBE = 2'h3,
      DPS_HOLD   = 2'h2
   } dps_state_t;
endpackage

/* File: dps_eng_if.sv */
`timescale 1ns/10ps
interface dps_eng_if;
   import dps_pkg::*;
   logic                start;
   dps_op_t             op;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                busy;
   logic                done;
   logic [DATA_W-1:0]   rdata;
   logic                conflict_seen;
   logic                conflict_lvl;
   logic                alert_lvl;

   modport ctl (output start, op, addr, wdata,
                input busy, done, rdata, conflict_seen, conflict_lvl, alert_lvl);
   modport eng (input start, op, addr, wdata,
                output busy, done, rdata, conflict_seen, conflict_lvl, alert_lvl);
endinterface

/* File: dps_host.sv */
`timescale 1ns/10ps
module dps_host
   import dps_pkg::*;
#(
   parameter logic [CNT_W-1:0] ACC_CYC = CNT_W'(ACCESS_CYC),
   parameter logic [CNT_W-1:0] SET_CYC = CNT_W'(SETUP_CYC)
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [31:0]             hrdata,
   output logic                    hresp,
   output logic                    irq,
   output logic [ADDR_W-1:0]       port_address,
   output logic [DATA_W-1:0]       port_data_out,
   output logic                    port_data_oe_n,
   input  wire logic [DATA_W-1:0]  port_data_in,
   output logic                    select_active_low_n,
   output logic                    select_active_high,
   output logic                    port_write_n,
   output logic                    port_output_enable_n,
   output logic                    flag_space_select_n,
   input  wire logic               port_conflict_n,
   input  wire logic               port_alert_n
);
   dps_eng_if eng_bus ();

   logic [ADDR_W-1:0]   addr_reg, next_addr_reg;
   logic [DATA_W-1:0]   wdata_reg, next_wdata_reg;
   dps_op_t             op_reg, next_op_reg;
   logic                start, next_start;
   logic [IRQ_W-1:0]    irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic                next_irq;
   logic [31:0]         next_hrdata;
   logic                wr_pend, next_wr_pend;
   logic [7:0]          wr_ofs, next_wr_ofs;
   logic                alert_q, next_alert_q;
   logic                addr_ok;
   logic [7:0]          ofs;
   logic [IRQ_W-1:0]    ev;

   function automatic logic [31:0] zext8(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   function automatic logic [31:0] zext_irq(input logic [IRQ_W-1:0] v);
      return {{(32-IRQ_W){1'b0}}, v};
   endfunction

   dps_port_engine #(
      .ACC_CYC (ACC_CYC),
      .SET_CYC (SET_CYC)
   ) u_engine (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .eng                  (eng_bus.eng),
      .port_address         (port_address),
      .port_data_out        (port_data_out),
      .port_data_oe_n       (port_data_oe_n),
      .port_data_in         (port_data_in),
      .select_active_low_n  (select_active_low_n),
      .select_active_high   (select_active_high),
      .port_write_n         (port_write_n),
      .port_output_enable_n (port_output_enable_n),
      .flag_space_select_n  (flag_space_select_n),
      .port_conflict_n      (port_conflict_n),
      .port_alert_n         (port_alert_n)
   );

   assign eng_bus.start = start;
   assign eng_bus.op    = op_reg;
   assign eng_bus.addr  = addr_reg;
   assign eng_bus.wdata = wdata_reg;

   assign addr_ok = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
   assign ofs     = haddr[7:0];

   // Alert fires on its falling edge so one pending notice sets one status bit
   always_comb begin
      ev               = '0;
      ev[IRQ_DONE]     = eng_bus.done;
      ev[IRQ_CONFLICT] = eng_bus.conflict_seen;
      ev[IRQ_ALERT]    = eng_bus.alert_lvl && !alert_q;
   end

   always_comb begin
      next_addr_reg  = addr_reg;
      next_wdata_reg = wdata_reg;
      next_op_reg    = op_reg;
      next_start     = 1'b0;
      next_irq_mask  = irq_mask;
      next_irq_stat  = irq_stat;
      next_hrdata    = hrdata;
      next_wr_pend   = 1'b0;
      next_wr_ofs    = wr_ofs;
      next_alert_q   = eng_bus.alert_lvl;
      // Data phase of a write lands here, one cycle after its address phase
      if (wr_pend) begin
         unique case (wr_ofs)
            OFS_ADDR:  next_addr_reg  = hwdata[ADDR_W-1:0];
            OFS_WDATA: next_wdata_reg = hwdata[DATA_W-1:0];
            OFS_MASK:  next_irq_mask  = hwdata[IRQ_W-1:0];
            OFS_CMD: begin
               // A command while the port is busy is dropped
               if (hwdata[CMD_START] && !eng_bus.busy && !start) begin
                  next_op_reg = dps_op_t'(hwdata[CMD_OP_HI:CMD_OP_LO]);
                  next_start  = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (addr_ok && hwrite) begin
         next_wr_pend = 1'b1;
         next_wr_ofs  = ofs;
      end
      if (addr_ok && !hwrite) begin
         unique case (ofs)
            OFS_ADDR:  next_hrdata = {16'h0000, addr_reg};
            OFS_WDATA: next_hrdata = zext8(wdata_reg);
            OFS_CMD:   next_hrdata = {29'h00000000, op_reg, 1'b0};
            OFS_STAT:  next_hrdata = zext_irq({eng_bus.alert_lvl, eng_bus.conflict_lvl,
                                               eng_bus.busy || start});
            OFS_RDATA: next_hrdata = zext8(eng_bus.rdata);
            OFS_IRQ: begin
               next_hrdata   = zext_irq(irq_stat);
               next_irq_stat = '0;
            end
            OFS_MASK:  next_hrdata = zext_irq(irq_mask);
            default:   next_hrdata = 32'h00000000;
         endcase
      end
      // Set wins over the read-clear in the same cycle
      next_irq_stat = next_irq_stat | ev;
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
         op_reg    <= DPS_OP_MEM_RD;
         start     <= 1'b0;
         irq_mask  <= '0;
         irq_stat  <= '0;
         irq       <= 1'b0;
         hrdata    <= 32'h00000000;
         wr_pend   <= 1'b0;
         wr_ofs    <= 8'h00;
         alert_q   <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         addr_reg  <= next_addr_reg;
         wdata_reg <= next_wdata_reg;
         op_reg    <= next_op_reg;
         start     <= next_start;
         irq_mask  <= next_irq_mask;
         irq_stat  <= next_irq_stat;
         irq       <= next_irq;
         hrdata    <= next_hrdata;
         wr_pend   <= next_wr_pend;
         wr_ofs    <= next_wr_ofs;
         alert_q   <= next_alert_q;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
endmodule

/* File: dps_host_properties.sv */
`timescale 1ns/10ps
module dps_host_properties
   import dps_pkg::*;
#(
   parameter logic [CNT_W-1:0] ACC_CYC = CNT_W'(ACCESS_CYC),
   parameter logic [CNT_W-1:0] SET_CYC = CNT_W'(SETUP_CYC)
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [ADDR_W-1:0] port_address,
   input wire logic [DATA_W-1:0] port_data_out,
   input wire logic              port_data_oe_n,
   input wire logic              select_active_low_n,
   input wire logic              select_active_high,
   input wire logic              port_write_n,
   input wire logic              port_output_enable_n,
   input wire logic              flag_space_select_n,
   input wire logic              port_conflict_n
);
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] next_low_cnt;
   logic             conf_hit;
   logic             next_conf_hit;
   logic             strobe_low;
   logic             mem_sel;
   assign strobe_low = !port_write_n || !port_output_enable_n;
   assign mem_sel = !select_active_low_n && select_active_high;
   always_comb begin
      next_low_cnt = strobe_low ? low_cnt + 1'b1 : '0;
      next_conf_hit = strobe_low && (conf_hit || !port_conflict_n);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt <= '0;
         conf_hit <= 1'b0;
      end else begin
         low_cnt <= next_low_cnt;
         conf_hit <= next_conf_hit;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence strobe_start;
      $fell(port_write_n) || $fell(port_output_enable_n);
   endsequence
   sequence strobe_end;
      $rose(port_write_n) || $rose(port_output_enable_n);
   endsequence
   // Sync delay on the conflict input: four samples leave margin before a freeze is due
   sequence conflict_run;
      (!port_conflict_n && mem_sel) [*4] ##0 !port_write_n;
   endsequence
   excl_select_a : assert property (!(mem_sel && !flag_space_select_n))
      else $error("memory and flag space selected together");
   read_nodrive_a : assert property (!port_output_enable_n |-> port_data_oe_n)
      else $error("host drives data while reading");
   write_drive_a : assert property (!port_write_n
      |-> !port_data_oe_n && $stable(port_data_out))
      else $error("write data not driven steadily");
   flag_addr_a : assert property (!flag_space_select_n
      |-> port_address[ADDR_W-1:FLAG_ADDR_W] == '0)
      else $error("flag access with upper address bits set");
   flag_load_a : assert property ($rose(port_write_n) && !flag_space_select_n
      |-> !port_data_oe_n && !mem_sel)
      else $error("flag load edge without data or while selected");
   strobe_setup_a : assert property (strobe_start
      |-> $past(mem_sel || !flag_space_select_n, SET_CYC)
      && !$past(mem_sel || !flag_space_select_n, SET_CYC + 1))
      else $error("strobe not preceded by exact setup");
   strobe_len_a : assert property (strobe_end |-> low_cnt == ACC_CYC || conf_hit)
      else $error("strobe length wrong");
   conflict_hold_a : assert property (conflict_run |=> !port_write_n)
      else $error("write strobe ended during conflict");
   reset_idle_a : assert property ($rose(hresetn)
      |-> select_active_low_n && !select_active_high
      && flag_space_select_n && port_write_n && port_output_enable_n && port_data_oe_n)
      else $error("port not idle after reset");
   bus_okay_a : assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
endmodule
bind dps_host dps_host_properties #(.ACC_CYC(ACC_CYC), .SET_CYC(SET_CYC)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .port_address(port_address), .port_data_out(port_data_out),
   .port_data_oe_n(port_data_oe_n), .select_active_low_n(select_active_low_n),
   .select_active_high(select_active_high), .port_write_n(port_write_n),
   .port_output_enable_n(port_output_enable_n), .flag_space_select_n(flag_space_select_n),
   .port_conflict_n(port_conflict_n));

/* File: dps_dev_model.sv */
`timescale 1ns/10ps
module dps_dev_model #(
   parameter bit ROLE_SOURCE = 1'b1
) (
   input  wire logic [15:0] address,
   input  wire logic [7:0]  host_data,
   input  wire logic        host_oe_n,
   input  wire logic        select_active_low_n,
   input  wire logic        select_active_high,
   input  wire logic        write_n,
   input  wire logic        output_enable_n,
   input  wire logic        flag_space_select_n,
   input  wire logic        conflict_req,
   input  wire logic        alert_req,
   output logic [7:0]       data_bus,
   output logic             conflict_n,
   output logic             alert_n
);
   logic [7:0] mem [0:65535];
   logic [7:0] flags = 8'h00;
   logic [7:0] held = 8'h5A;
   logic       selected;
   logic       mem_rd;
   logic       flag_rd;
   logic [7:0] val;
   assign selected = !select_active_low_n && select_active_high;
   assign mem_rd = selected && flag_space_select_n && write_n && !output_enable_n;
   assign flag_rd = !selected && !flag_space_select_n && write_n && !output_enable_n;
   assign val = mem_rd ? mem[address] : {8{flags[address[2:0]]}};
   always @* begin
      if (mem_rd || flag_rd)
         held = val;
   end
   // Released lines show the inverse of the last byte so a stale sample cannot match
   assign data_bus = !host_oe_n ? host_data : ((mem_rd || flag_rd) ? val : ~held);
   always @(posedge write_n) begin
      if (selected && flag_space_select_n && conflict_n)
         mem[address] <= host_data;
      if (!selected && !flag_space_select_n)
         flags[address[2:0]] <= host_data[0];
   end
   assign conflict_n = !(ROLE_SOURCE && conflict_req);
   assign alert_n = !alert_req;
endmodule

/* File: dps_host_tb_top.sv */
`timescale 1ns/10ps
module dps_host_tb_top;
   import dps_pkg::*;
   logic hclk, hresetn, hwrite, conflict_req, alert_req;
   logic [31:0] haddr, hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire [31:0]  hrdata;
   wire         hready, hresp, irq, data_oe_n, sel_n, sel, write_n, oe_n, flag_n, conf_n, alert_n;
   wire [15:0]  paddr;
   wire [7:0]   data_out, data_bus;
   int bad_count, num_checks;
   always #2 hclk = ~hclk;
   dps_host #(.ACC_CYC(8'h08), .SET_CYC(8'h02)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hrdata(hrdata), .hresp(hresp), .irq(irq), .port_address(paddr),
      .port_data_out(data_out), .port_data_oe_n(data_oe_n), .port_data_in(data_bus),
      .select_active_low_n(sel_n), .select_active_high(sel), .port_write_n(write_n),
      .port_output_enable_n(oe_n), .flag_space_select_n(flag_n),
      .port_conflict_n(conf_n), .port_alert_n(alert_n));
   dps_dev_model u_dev (
      .address(paddr), .host_data(data_out), .host_oe_n(data_oe_n),
      .select_active_low_n(sel_n), .select_active_high(sel), .write_n(write_n),
      .output_enable_n(oe_n), .flag_space_select_n(flag_n), .conflict_req(conflict_req),
      .alert_req(alert_req), .data_bus(data_bus), .conflict_n(conf_n), .alert_n(alert_n));
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic issue(input dps_op_t op, input logic [15:0] a, input logic [7:0] d);
      wr(OFS_ADDR, {16'h0, a});
      wr(OFS_WDATA, {24'h0, d});
      wr(OFS_CMD, {29'h0, op, 1'b1});
   endtask
   // Waits on the port pins, not on IRQ, so polling never clears pending events
   task automatic finish;
      int n;
      n = 0;
      while (sel_n && flag_n && n < 50) begin
         @(posedge hclk);
         n++;
      end
      chk(32'(n < 50), 32'h1);
      while (!(sel_n && flag_n) && n < 500) begin
         @(posedge hclk);
         n++;
      end
      chk(32'(n < 500), 32'h1);
      repeat (2) @(posedge hclk);
   endtask
   task automatic t_regs;
      rd_chk(OFS_STAT, 32'h0);
      rd_chk(OFS_IRQ, 32'h0);
      rd_chk(OFS_MASK, 32'h0);
      rd_chk(OFS_ADDR, 32'h0);
      wr(OFS_MASK, 32'hFFFFFFFF);
      rd_chk(OFS_MASK, 32'h7);
      wr(OFS_ADDR, 32'hFFFFFFFF);
      rd_chk(OFS_ADDR, 32'h0000FFFF);
      wr(8'h1C, 32'h12345678);
      rd_chk(8'h1C, 32'h0);
      wr(OFS_STAT, 32'h7);
      rd_chk(OFS_STAT, 32'h0);
      wr(OFS_MASK, 32'h0);
   endtask
   task automatic t_mem;
      logic [15:0] ta [3] = '{16'h0000, 16'hFFFF, 16'h8001};
      for (int i = 0; i < 3; i++) begin
         issue(DPS_OP_MEM_WR, ta[i], 8'hA5 ^ ta[i][15:8]);
         finish;
      end
      for (int i = 0; i < 3; i++) begin
         issue(DPS_OP_MEM_RD, ta[i], 8'h00);
         finish;
         rd_chk(OFS_RDATA, {24'h0, 8'hA5 ^ ta[i][15:8]});
      end
   endtask
   task automatic t_flags;
      issue(DPS_OP_MEM_WR, 16'h0005, 8'h3C);
      finish;
      for (int i = 0; i < 8; i++) begin
         issue(DPS_OP_FLAG_WR, {13'h1FFF, i[2:0]}, {7'h55, i[0] ^ i[2]});
         finish;
      end
      for (int i = 0; i < 8; i++) begin
         issue(DPS_OP_FLAG_RD, {13'h0000, i[2:0]}, 8'h00);
         finish;
         rd_chk(OFS_RDATA, {24'h0, {8{i[0] ^ i[2]}}});
      end
      rd_chk(OFS_CMD, {29'h0, DPS_OP_FLAG_RD, 1'b0});
      issue(DPS_OP_MEM_RD, 16'h0005, 8'h00);
      finish;
      rd_chk(OFS_RDATA, 32'h3C);
   endtask
   task automatic t_conflict;
      int n;
      rd_chk(OFS_IRQ, 32'h1);
      issue(DPS_OP_MEM_WR, 16'h1234, 8'hC3);
      n = 0;
      while (write_n && n < 50) begin
         @(posedge hclk);
         n++;
      end
      conflict_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rd_chk(OFS_STAT, 32'h1 << ST_BUSY | 32'h1 << ST_CONFLICT);
      // A command while the port is busy must be dropped
      wr(OFS_CMD, {29'h0, DPS_OP_FLAG_RD, 1'b1});
      rd_chk(OFS_CMD, {29'h0, DPS_OP_MEM_WR, 1'b0});
      repeat (4) @(posedge hclk);
      chk(32'(write_n), 32'h0);
      conflict_req <= 1'b0;
      finish;
      rd_chk(OFS_IRQ, 32'h1 << IRQ_DONE | 32'h1 << IRQ_CONFLICT);
      issue(DPS_OP_MEM_RD, 16'h1234, 8'h00);
      finish;
      rd_chk(OFS_RDATA, 32'hC3);
   endtask
   task automatic t_irq;
      rd_chk(OFS_IRQ, 32'h1);
      wr(OFS_MASK, 32'h1 << IRQ_DONE);
      issue(DPS_OP_MEM_RD, 16'hFFFF, 8'h00);
      finish;
      chk(32'(irq), 32'h1);
      rd_chk(OFS_IRQ, 32'h1 << IRQ_DONE);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      wr(OFS_MASK, 32'h1 << IRQ_ALERT);
      alert_req <= 1'b1;
      repeat (5) @(posedge hclk);
      chk(32'(irq), 32'h1);
      rd_chk(OFS_STAT, 32'h1 << ST_ALERT);
      alert_req <= 1'b0;
      rd_chk(OFS_IRQ, 32'h1 << IRQ_ALERT);
      repeat (5) @(posedge hclk);
      rd_chk(OFS_IRQ, 32'h0);
      chk(32'(irq), 32'h0);
      issue(DPS_OP_FLAG_RD, 16'h0001, 8'h00);
      finish;
      chk(32'(irq), 32'h0);
      rd_chk(OFS_IRQ, 32'h1 << IRQ_DONE);
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      conflict_req = 1'b0;
      alert_req = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_mem;
      t_flags;
      t_conflict;
      t_irq;
      give_verdict;
   end
   initial begin
      #80000;
      bad_count++;
      give_verdict;
   end
endmodule
